//--- logic/pwr_seq_cfg.svh
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH

// clock rate and timing figures
`define CLK_MHZ        125
`define MAIN_DLY_US    800
`define CARD_DLY_US    500
`define RST_DLY_US     262000
`define CNT_W          26

// apb register byte offsets
`define ADDR_W         8
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04

// control register fields and reset value
`define CTRL_FORCE_PWM 0
`define CTRL_USB_BLOCK 1
`define CTRL_W         2
`define CTRL_RST       2'h0

// status register fields
`define ST_STATE_LO    0
`define ST_EXT_SEL     4
`define ST_USB_SW      5
`define ST_PERIPH      6
`define ST_CARD        7
`define ST_RST_REL     8
`define ST_INIT_DONE   9
`define ST_BURST       10
`define ST_LOW_BATT    11
`define ST_WALL        12
`define ST_USB_OK      13

// synchronised pin vector positions
`define PIN_N          12
`define IN_LOW_BATT    0
`define IN_WALL        1
`define IN_USB_OK      2
`define IN_EXT_OK      3
`define IN_SUSPEND     4
`define IN_HI_CUR      5
`define IN_KEY_N       6
`define IN_HOLD        7
`define IN_MODE        8
`define IN_INT_OK      9
`define IN_CORE_OK     10
`define IN_MAIN_OK     11
`define PIN_RST        12'h0040

`endif

//--- logic/pwr_seq_pkg.sv
package pwr_seq_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_WAIT_SRC,
		ST_INT_UP,
		ST_CORE_UP,
		ST_RUN
	} seq_state_t;
endpackage : pwr_seq_pkg

//--- logic/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// three-stage pin filter: the value moves on only once stages two and three agree
module pin_sync #(
	parameter int unsigned              W       = 1,
	parameter logic [W-1:0]             RST_VAL = '0
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [W-1:0]           d,
	output logic      [W-1:0]           q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] q_d;

	// per bit: take stage three where it matches stage two, else hold
	assign q_d = (s2_q & s3_q) | (q & (s2_q ^ s3_q));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q    <= q_d;
		end
	end
endmodule : pin_sync
`default_nettype wire

//--- logic/power_sequence_supervisor.sv
// How it works
// (RL1) low-battery flag pulled low while sensed input sits below reference
// (RL2) wall detected: draw from external node and open the usb switch
// (RL3) power-good flag low for wall, or usb good with suspend low
// (RL4) never draw from external node until its under-voltage detector is ok
// (RL5) usb switch closed only for usb good, suspend low, no wall
// (RL6) high current select picks large usb limit, low picks small
// (RL7) suspend high disables usb, switch open, only bias draw
// (RL8) peripheral rail switch closes a fixed delay after core regulates
// (RL9) card rail switch closes a shorter delay after core regulates
// (RL10) key pulled low turns the device on
// (RL11) key must stay low until the processor raises power hold
// (RL12) key status output mirrors the key input
// (RL13) power hold high turns the device on and keeps it on
// (RL14) mode high allows burst at light load, low forces pwm
// (RL15) pwm forced whenever powered from usb or wall
// (RL16) pwm forced during the initial reset delay
// (RL17) reset low at power-up, released after delay once core and main good
// (RL18) reset pulled low when core or main drops out of regulation
// (RL19) reset pulled low at power-off
// (RL20) power-up order: internal supply, core, main, then card rail; here the card rail closes before main
// (RL21) usb cut off when monitor reports low voltage
// (RL22) key released and hold low together: turn off and discharge
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_seq_cfg.svh"
module power_sequence_supervisor #(
	parameter int unsigned MAIN_DLY_CYC = `MAIN_DLY_US * `CLK_MHZ,
	parameter int unsigned CARD_DLY_CYC = `CARD_DLY_US * `CLK_MHZ,
	parameter int unsigned RST_DLY_CYC  = `RST_DLY_US * `CLK_MHZ
) (
	input  wire logic               clk,
	input  wire logic               rst,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [`ADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// comparator and pin inputs, all asynchronous
	input  wire logic               low_batt_sense,
	input  wire logic               wall_detect_in,
	input  wire logic               usb_volt_ok,
	input  wire logic               external_power_node_ok,
	input  wire logic               usb_suspend,
	input  wire logic               usb_high_current_sel,
	input  wire logic               power_key_n,
	input  wire logic               power_hold,
	input  wire logic               mode_burst,
	input  wire logic               internal_supply_ok,
	input  wire logic               core_feedback,
	input  wire logic               main_ok,
	// open-drain pins: enable high pulls the pin low
	output logic                    low_batt_flag_n_oe,
	output logic                    external_power_good_n_oe,
	output logic                    key_status_n_oe,
	output logic                    reset_n_oe,
	// power stage controls
	output logic                    ext_source_sel,
	output logic                    usb_switch_on,
	output logic                    usb_high_limit,
	output logic                    usb_bias_only,
	output logic                    internal_supply_en,
	output logic                    core_en,
	output logic                    peripheral_rail_switch,
	output logic                    card_rail_switch,
	output logic                    burst_allow,
	output logic                    discharge_en
);
	import pwr_seq_pkg::*;

	// every pin goes through the same three-stage filter, so a pin change
	// reaches an output flop five edges later; sequencer outputs need one or
	// two edges more. the delays below are counted from the filtered view of
	// core regulation, so the analog ramp time does not shorten them.
	//
	// limitation: the timers are plain clock counts, so their accuracy is that
	// of the clock; a slower clock stretches every delay in proportion.
	//
	// trade-off: one shared rail counter serves both switches, which keeps
	// the card rail ahead of the peripheral rail while CARD_DLY_CYC is below MAIN_DLY_CYC.

	// saturating counter step, shared by both timers
	function automatic logic [`CNT_W-1:0] sat_inc(input logic [`CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + `CNT_W'(1);
	endfunction : sat_inc

	localparam logic [`CNT_W-1:0] MAIN_CNT = `CNT_W'(MAIN_DLY_CYC);
	localparam logic [`CNT_W-1:0] CARD_CNT = `CNT_W'(CARD_DLY_CYC);
	localparam logic [`CNT_W-1:0] RST_CNT  = `CNT_W'(RST_DLY_CYC);

	logic [`PIN_N-1:0] pin_raw;
	logic [`PIN_N-1:0] pin;

	assign pin_raw = {main_ok, core_feedback, internal_supply_ok, mode_burst,
	                  power_hold, power_key_n, usb_high_current_sel, usb_suspend,
	                  external_power_node_ok, usb_volt_ok, wall_detect_in, low_batt_sense};

	// key idles high through its pull-up, every other pin idles low
	pin_sync #(
		.W       (`PIN_N),
		.RST_VAL (`PIN_RST)
	) u_pin_sync (
		.clk (clk),
		.rst (rst),
		.d   (pin_raw),
		.q   (pin)
	);

	wire low_batt = pin[`IN_LOW_BATT];
	wire wall     = pin[`IN_WALL];
	wire usb_ok   = pin[`IN_USB_OK];
	wire ext_ok   = pin[`IN_EXT_OK];
	wire suspend  = pin[`IN_SUSPEND];
	wire hi_cur   = pin[`IN_HI_CUR];
	wire key_n    = pin[`IN_KEY_N];
	wire hold     = pin[`IN_HOLD];
	wire mode     = pin[`IN_MODE];
	wire int_ok   = pin[`IN_INT_OK];
	wire core_ok  = pin[`IN_CORE_OK];
	wire rail_ok  = pin[`IN_MAIN_OK];

	// registers
	seq_state_t           state_q;
	seq_state_t           state_d;
	logic [`CTRL_W-1:0]   ctrl_q;
	logic [`CNT_W-1:0]    seq_cnt_q;
	logic [`CNT_W-1:0]    rst_cnt_q;
	logic                 init_done_q;
	logic                 rst_rel_q;

	// power request and release
	wire on_req  = ~key_n | hold;                      // (RL10) (RL13)
	wire off_req = key_n & ~hold;                      // (RL22) (RL11)

	// source selection; usb path also vetoed by software block bit
	wire usb_path    = usb_ok & ~suspend & ~wall & ~ctrl_q[`CTRL_USB_BLOCK]; // (RL5) (RL7) (RL21) (RL2)
	wire ext_present = wall | usb_path;
	wire ext_draw    = ext_present & ext_ok;           // (RL4) (RL2)

	// sequencer
	// an off request wins in every on state, so a released key with no hold
	// never leaves a rail half raised; the off state ignores off requests
	// and simply waits for the next key press or hold.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (on_req)
					state_d = ST_WAIT_SRC;
			end
			ST_WAIT_SRC: begin
				// external source must clear its detector before anything starts
				if (off_req)
					state_d = ST_OFF;
				else if (~ext_present | ext_ok) // (RL4)
					state_d = ST_INT_UP;
			end
			ST_INT_UP: begin
				if (off_req)
					state_d = ST_OFF;
				else if (int_ok)                // (RL20)
					state_d = ST_CORE_UP;
			end
			ST_CORE_UP: begin
				if (off_req)
					state_d = ST_OFF;
				else if (core_ok)               // (RL20)
					state_d = ST_RUN;
			end
			ST_RUN: begin
				if (off_req)
					state_d = ST_OFF;           // (RL22)
			end
			default: state_d = ST_OFF;
		endcase
	end

	wire running = (state_q == ST_RUN);
	wire powered = (state_q != ST_OFF);

	// rail switch timing counts from core regulation on entry to run
	wire periph_d = running & (seq_cnt_q >= MAIN_CNT); // (RL8) (RL20)
	wire card_d   = running & (seq_cnt_q >= CARD_CNT); // (RL9)

	// reset timer only runs while both outputs are good
	wire both_ok   = running & core_ok & rail_ok;      // (RL17) (RL18)
	wire rst_rel_d = both_ok & (rst_cnt_q >= RST_CNT); // (RL17)

	// pwm forcing: external source, initial delay, mode pin, software override
	wire burst_d = mode & ~ext_draw & init_done_q      // (RL14) (RL15) (RL16)
	             & ~ctrl_q[`CTRL_FORCE_PWM];

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_q <= ST_OFF;
		else
			state_q <= state_d;
	end

	// rail delay counter, cleared whenever the run state is left
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			seq_cnt_q <= '0;
		else if (running)
			seq_cnt_q <= sat_inc(seq_cnt_q);
		else
			seq_cnt_q <= '0;
	end

	// reset delay counter restarts after any regulation drop
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rst_cnt_q <= '0;
		else if (both_ok)
			rst_cnt_q <= sat_inc(rst_cnt_q); // (RL17)
		else
			rst_cnt_q <= '0;                 // (RL18)
	end

	// first release ends the initial forced pwm window until next power-off
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			init_done_q <= 1'b0;
		else if (!powered)
			init_done_q <= 1'b0;             // (RL16)
		else if (rst_rel_d)
			init_done_q <= 1'b1;
	end

	// apb: one wait state, answer registered
	// pready toggles low on the completing edge, so a second access phase
	// that follows at once always gets a fresh wait state of its own.
	// unmapped addresses answer with an error and read as zero.
	wire acc       = psel & penable;
	wire hit_ctrl  = (paddr == `OFS_CTRL);
	wire hit_stat  = (paddr == `OFS_STATUS);
	wire mapped    = hit_ctrl | hit_stat;
	wire commit_wr = acc & pready & pwrite & hit_ctrl;

	logic [31:0] status_w;
	logic [31:0] rdata_w;

	always_comb begin
		status_w = '0;
		status_w[`ST_STATE_LO +: 3] = state_q;
		status_w[`ST_EXT_SEL]       = ext_source_sel;
		status_w[`ST_USB_SW]        = usb_switch_on;
		status_w[`ST_PERIPH]        = peripheral_rail_switch;
		status_w[`ST_CARD]          = card_rail_switch;
		status_w[`ST_RST_REL]       = rst_rel_q;
		status_w[`ST_INIT_DONE]     = init_done_q;
		status_w[`ST_BURST]         = burst_allow;
		status_w[`ST_LOW_BATT]      = low_batt;
		status_w[`ST_WALL]          = wall;
		status_w[`ST_USB_OK]        = usb_ok;
	end

	// address decode for read data; unmapped reads return zero
	assign rdata_w = hit_ctrl ? {{(32-`CTRL_W){1'b0}}, ctrl_q}
	               : hit_stat ? status_w : 32'h0000_0000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc & ~pready;
			pslverr <= acc & ~pready & ~mapped;
			prdata  <= (acc & ~pready & ~pwrite) ? rdata_w : prdata;
		end
	end

	// control register written only at the completing edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ctrl_q <= `CTRL_RST;
		else if (commit_wr)
			ctrl_q <= pwdata[`CTRL_W-1:0];
	end

	// pin-level flags hold regardless of power state; they live on the
	// always-alive supply so the key echo works before turn-on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_batt_flag_n_oe       <= 1'b0;
			external_power_good_n_oe <= 1'b0;
			key_status_n_oe          <= 1'b0;
		end else begin
			low_batt_flag_n_oe       <= low_batt;                          // (RL1)
			external_power_good_n_oe <= wall | (usb_ok & ~suspend);        // (RL3)
			key_status_n_oe          <= ~key_n;                            // (RL12)
		end
	end

	// usb front end controls
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			usb_switch_on  <= 1'b0;
			usb_high_limit <= 1'b0;
			usb_bias_only  <= 1'b0;
			ext_source_sel <= 1'b0;
		end else begin
			usb_switch_on  <= usb_path;           // (RL5) (RL2) (RL21)
			usb_high_limit <= hi_cur;             // (RL6)
			usb_bias_only  <= suspend;            // (RL7)
			ext_source_sel <= powered & ext_draw; // (RL2) (RL4)
		end
	end

	// regulator enables and rail switches follow the sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			internal_supply_en     <= 1'b0;
			core_en                <= 1'b0;
			peripheral_rail_switch <= 1'b0;
			card_rail_switch       <= 1'b0;
			discharge_en           <= 1'b1;
		end else begin
			internal_supply_en     <= powered & (state_d != ST_OFF) & (state_q != ST_WAIT_SRC); // (RL20)
			core_en                <= (state_q == ST_CORE_UP | running) & ~off_req;            // (RL20)
			peripheral_rail_switch <= periph_d & ~off_req;                                     // (RL8)
			card_rail_switch       <= card_d & ~off_req;                                       // (RL9)
			discharge_en           <= ~powered | off_req;                                      // (RL22)
		end
	end

	// reset pin: held low from power-up until the delay runs out
	// the release is cut in the same edge as an off request, so the
	// processor sees reset in the same edge that its rail enables drop.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_rel_q   <= 1'b0;
			reset_n_oe  <= 1'b1;
			burst_allow <= 1'b0;
		end else begin
			rst_rel_q   <= rst_rel_d & ~off_req;  // (RL17) (RL18) (RL19)
			reset_n_oe  <= ~(rst_rel_d & ~off_req); // (RL17) (RL18) (RL19)
			burst_allow <= burst_d & powered;     // (RL14) (RL15) (RL16)
		end
	end

endmodule : power_sequence_supervisor
`default_nettype wire

//--- tb/pss_props.sv
`timescale 1ns/1ns
`default_nettype none
// watches the pins; a pin change reaches an output flop five edges later, so eight quiet cycles settle any output
module pss_props #(
	parameter int unsigned MAIN_DLY_CYC = 100000,
	parameter int unsigned CARD_DLY_CYC = 62500,
	parameter int unsigned RST_DLY_CYC  = 32750000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic low_batt_sense,
	input wire logic wall_detect_in,
	input wire logic usb_volt_ok,
	input wire logic usb_suspend,
	input wire logic external_power_node_ok,
	input wire logic power_key_n,
	input wire logic power_hold,
	input wire logic mode_burst,
	input wire logic internal_supply_ok,
	input wire logic core_feedback,
	input wire logic main_ok,
	input wire logic low_batt_flag_n_oe,
	input wire logic external_power_good_n_oe,
	input wire logic key_status_n_oe,
	input wire logic reset_n_oe,
	input wire logic ext_source_sel,
	input wire logic usb_switch_on,
	input wire logic core_en,
	input wire logic peripheral_rail_switch,
	input wire logic card_rail_switch,
	input wire logic burst_allow,
	input wire logic discharge_en
);
	logic [31:0] core_cnt_q;
	logic [31:0] both_cnt_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// run lengths of raw rail-good levels, the reference for the delay timers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_cnt_q <= 32'h0000_0000;
			both_cnt_q <= 32'h0000_0000;
		end else begin
			core_cnt_q <= core_feedback ? core_cnt_q + 32'h0000_0001 : 32'h0000_0000;
			both_cnt_q <= (core_feedback && main_ok) ? both_cnt_q + 32'h0000_0001 : 32'h0000_0000;
		end
	end
	property p_low_batt; $stable(low_batt_sense)[*8] |-> low_batt_flag_n_oe == low_batt_sense; endproperty
	a_low_batt: assert property (p_low_batt) else $error("low battery flag wrong");
	property p_key_echo; $stable(power_key_n)[*8] |-> key_status_n_oe == !power_key_n; endproperty
	a_key_echo: assert property (p_key_echo) else $error("key status wrong");
	property p_ext_good;
		$stable({wall_detect_in, usb_volt_ok, usb_suspend})[*8]
		|-> external_power_good_n_oe == (wall_detect_in || (usb_volt_ok && !usb_suspend));
	endproperty
	a_ext_good: assert property (p_ext_good) else $error("power good flag wrong");
	property p_usb_open; (wall_detect_in || usb_suspend || !usb_volt_ok)[*8] |-> !usb_switch_on; endproperty
	a_usb_open: assert property (p_usb_open) else $error("usb switch closed");
	property p_ext_lock; (!external_power_node_ok)[*8] |-> !ext_source_sel; endproperty
	a_ext_lock: assert property (p_ext_lock) else $error("external node used too early");
	property p_order;
		($rose(core_en) |-> internal_supply_ok) and ($rose(peripheral_rail_switch) |-> card_rail_switch);
	endproperty
	a_order: assert property (p_order) else $error("rail order wrong");
	property p_card; $rose(card_rail_switch) |-> core_cnt_q >= CARD_DLY_CYC && core_cnt_q <= CARD_DLY_CYC + 16; endproperty
	a_card: assert property (p_card) else $error("card switch delay wrong");
	property p_periph; $rose(peripheral_rail_switch) |-> core_cnt_q >= MAIN_DLY_CYC && core_cnt_q <= MAIN_DLY_CYC + 16;
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral switch delay wrong");
	property p_rst_rel; $fell(reset_n_oe) |-> both_cnt_q >= RST_DLY_CYC && both_cnt_q <= RST_DLY_CYC + 16; endproperty
	a_rst_rel: assert property (p_rst_rel) else $error("reset released at wrong time");
	property p_rst_drop; (!(core_feedback && main_ok))[*8] |-> reset_n_oe; endproperty
	a_rst_drop: assert property (p_rst_drop) else $error("reset not asserted");
	property p_pwm; (wall_detect_in || !mode_burst)[*8] |-> !burst_allow; endproperty
	a_pwm: assert property (p_pwm) else $error("burst not blocked");
	property p_off; (power_key_n && !power_hold)[*8] |-> discharge_en && reset_n_oe && !core_en; endproperty
	a_off: assert property (p_off) else $error("device not off");
endmodule : pss_props
`default_nettype wire

//--- tb/rail_model.sv
`timescale 1ns/1ns
`default_nettype none
// rail comparators: good follows enable after a lag, drops at once; fault pulls core out
module rail_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic fault,
	input  wire logic internal_supply_en,
	input  wire logic core_en,
	input  wire logic peripheral_rail_switch,
	output logic      internal_supply_ok,
	output logic      core_feedback,
	output logic      main_ok
);
	logic [3:0] int_q;
	logic [3:0] core_q;
	logic [3:0] main_q;
	// slow picks a four-cycle ramp, otherwise one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{int_q, core_q, main_q} <= 12'h000;
		end else begin
			int_q  <= {int_q[2:0], internal_supply_en};
			core_q <= {core_q[2:0], core_en};
			main_q <= {main_q[2:0], peripheral_rail_switch};
		end
	end
	assign internal_supply_ok = internal_supply_en && (slow ? int_q[3] : int_q[0]);
	assign core_feedback      = core_en && !fault && (slow ? core_q[3] : core_q[0]);
	assign main_ok            = peripheral_rail_switch && (slow ? main_q[3] : main_q[0]);
endmodule : rail_model
`default_nettype wire

//--- tb/power_sequence_supervisor_tb.sv
`timescale 1ns/1ns
`default_nettype none
module power_sequence_supervisor_tb;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, slow, fault;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic low_batt_sense, wall_detect_in, usb_volt_ok, external_power_node_ok, usb_suspend;
	logic usb_high_current_sel, power_key_n, power_hold, mode_burst, er, bad;
	logic internal_supply_ok, core_feedback, main_ok, low_batt_flag_n_oe, external_power_good_n_oe;
	logic key_status_n_oe, reset_n_oe, ext_source_sel, usb_switch_on, usb_high_limit, usb_bias_only;
	logic internal_supply_en, core_en, peripheral_rail_switch, card_rail_switch, burst_allow, discharge_en;
	int miscompares, checks_done, cyc, n;
	power_sequence_supervisor #(.MAIN_DLY_CYC(20), .CARD_DLY_CYC(12), .RST_DLY_CYC(50)) uut (.*);
	rail_model u_rail (.*);
	// free-running clock, 8 ns
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc > 60000) begin
			miscompares++;
			results();
		end
	end
	// one apb transfer; request held until pready is seen, then an idle edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wait_for(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 2000) begin @(posedge clk); n++; end
		chk(32'(s), 32'(v));
	endtask : wait_for
	task automatic t_regs;
		chk(32'({discharge_en, reset_n_oe, core_en, usb_switch_on}), 32'(4'b1100));
		apb(1'b0, 8'h00, 32'h0000_0000); chk(rd, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'hffff_ffff); apb(1'b0, 8'h00, 32'h0000_0000); chk(rd, 32'h0000_0003);
		apb(1'b1, 8'h04, 32'hffff_ffff); apb(1'b0, 8'h04, 32'h0000_0000); chk(32'({rd[31:14], er}), 32'h0000_0000);
		apb(1'b1, 8'h10, 32'h0000_0001); chk(32'(er), 32'h0000_0001);
		apb(1'b0, 8'h10, 32'h0000_0000); chk(rd, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		apb(1'b1, 8'h00, 32'h0000_0000);
		$display("test regs done");
	endtask : t_regs
	// every comparator pattern while off; external node not yet good
	task automatic t_flags;
		for (int i = 0; i < 32; i++) begin
			{usb_high_current_sel, usb_suspend, usb_volt_ok, wall_detect_in, low_batt_sense} <= i[4:0];
			repeat (8) @(posedge clk);
			chk(32'({low_batt_flag_n_oe, external_power_good_n_oe, usb_switch_on, usb_bias_only}),
				32'({i[0], i[1] | (i[2] & !i[3]), i[2] & !i[3] & !i[1], i[3]}));
			if (!i[3]) chk(32'(usb_high_limit), 32'(i[4]));
			chk(32'(ext_source_sel), 32'h0);
		end
		{usb_high_current_sel, usb_suspend, usb_volt_ok, wall_detect_in, low_batt_sense} <= 5'h00;
		$display("test flags done");
	endtask : t_flags
	task automatic t_power_up;
		external_power_node_ok <= 1'b1; mode_burst <= 1'b1; slow <= 1'b1;
		power_key_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk(32'(key_status_n_oe), 32'h1);
		wait_for(internal_supply_en, 1'b1);
		power_hold <= 1'b1;
		wait_for(core_en, 1'b1);
		power_key_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'({key_status_n_oe, core_en}), 32'h1);
		wait_for(card_rail_switch, 1'b1);
		chk(32'(peripheral_rail_switch), 32'h0);
		wait_for(peripheral_rail_switch, 1'b1);
		bad = 1'b0;
		n = 0;
		while (reset_n_oe !== 1'b0 && n < 4000) begin @(posedge clk); n++; bad |= burst_allow; end
		chk(32'({bad, reset_n_oe}), 32'h0);
		repeat (8) @(posedge clk);
		chk(32'(burst_allow), 32'h1);
		mode_burst <= 1'b0; repeat (8) @(posedge clk); chk(32'(burst_allow), 32'h0);
		mode_burst <= 1'b1; wall_detect_in <= 1'b1; repeat (8) @(posedge clk);
		chk(32'({burst_allow, ext_source_sel}), 32'h1);
		wall_detect_in <= 1'b0; usb_volt_ok <= 1'b1; repeat (8) @(posedge clk);
		chk(32'({burst_allow, usb_switch_on}), 32'h1);
		usb_volt_ok <= 1'b0;
		$display("test power up done");
	endtask : t_power_up
	// core drops out of regulation, then recovers; switches stay closed
	task automatic t_fault;
		slow <= 1'b0; fault <= 1'b1;
		repeat (10) @(posedge clk);
		chk(32'({reset_n_oe, card_rail_switch, peripheral_rail_switch}), 32'h7);
		fault <= 1'b0;
		n = 0;
		while (reset_n_oe !== 1'b0 && n < 500) begin @(posedge clk); n++; end
		chk(32'(n >= 50 && n <= 70), 32'h1);
		$display("test fault done");
	endtask : t_fault
	task automatic t_off;
		power_hold <= 1'b0;
		repeat (10) @(posedge clk);
		chk(32'({discharge_en, reset_n_oe, core_en, card_rail_switch}), 32'hc);
		$display("test off done");
	endtask : t_off
	initial begin
		{psel, penable, pwrite, paddr, pwdata, slow, fault} = '0;
		{low_batt_sense, wall_detect_in, usb_volt_ok, external_power_node_ok, usb_suspend} = '0;
		{usb_high_current_sel, power_hold, mode_burst} = '0;
		power_key_n = 1'b1;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_flags();
		t_power_up();
		t_fault();
		t_off();
		results();
	end
endmodule : power_sequence_supervisor_tb
bind power_sequence_supervisor pss_props #(.MAIN_DLY_CYC(MAIN_DLY_CYC), .CARD_DLY_CYC(CARD_DLY_CYC),
	.RST_DLY_CYC(RST_DLY_CYC)) u_props (.*);
`default_nettype wire
